// ---- rtl/blr_pkg.sv ----
`default_nettype none
package blr_pkg;
   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam int MODE_W = 4;

   // register indices on the control port
   localparam logic [5:0] BUCK_FOUR_LEVELS_ADDR = 6'h1b;
   localparam logic [5:0] BUCK_ONE_TWO_MODES_ADDR = 6'h1c;
   localparam logic [5:0] BUCK_THREE_FOUR_MODES_ADDR = 6'h1d;
   localparam logic [5:0] LINEAR_REGULATOR_LEVELS_ADDR = 6'h1e;

   // buck_four_levels fields
   localparam int B4_NORMAL_LSB = 0;
   localparam int B4_SPARE_LSB = 5;
   localparam int B4_STANDBY_LSB = 10;
   localparam int B4_RANGE_BIT = 23;

   // buck_one_two_modes fields
   localparam int B1_MODE_LSB = 0;
   localparam int B1_HOLD_BIT = 4;
   localparam int B1_USER_OFF_BIT = 5;
   localparam int B1_SPEED_LSB = 6;
   localparam int SIGNAL_SCALING_BIT = 8;
   localparam int B2_MODE_LSB = 10;
   localparam int B2_HOLD_BIT = 14;
   localparam int B2_USER_OFF_BIT = 15;
   localparam int B2_SPEED_LSB = 16;
   localparam int PLL_ENABLE_BIT = 18;
   localparam int PLL_MULT_LSB = 19;
   localparam int ILIM_DISABLE_BIT = 22;

   // buck_three_four_modes fields
   localparam int B3_MODE_LSB = 0;
   localparam int B3_HOLD_BIT = 4;
   localparam int B3_USER_OFF_BIT = 5;
   localparam int B4_MODE_LSB = 8;
   localparam int B4_HOLD_BIT = 12;
   localparam int B4_USER_OFF_BIT = 13;
   localparam int BOOST_ENABLE_BIT = 20;

   // linear_regulator_levels fields
   localparam int GEN1_LSB = 0;
   localparam int DIGITAL_LSB = 4;
   localparam int GEN2_LSB = 6;
   localparam int PLL_REG_LSB = 9;
   localparam int USB2_LSB = 11;
   localparam int GEN3_BIT = 14;
   localparam int CAMERA_LSB = 16;
   localparam int LIN_SPARE_BIT = 18;

   // reset values of single fields
   localparam logic [3:0] MODE_RESET = 4'ha;
   localparam logic [1:0] SPEED_RESET = 2'h1;
   localparam logic [2:0] PLL_MULT_RESET = 3'h4;
   localparam logic [1:0] CAMERA_RESET = 2'h2;

   // per register: bits on main reset, on off reset, with no reset
   localparam logic [23:0] R27_MAIN_MASK = 24'h000000;
   localparam logic [23:0] R27_OFF_MASK = 24'h000000;
   localparam logic [23:0] R27_KEEP_MASK = 24'h807fff;
   localparam logic [23:0] R27_RESET = 24'h000000;

   localparam logic [23:0] R28_MAIN_MASK = 24'h7f3dcf;
   localparam logic [23:0] R28_OFF_MASK = 24'h00c030;
   localparam logic [23:0] R28_KEEP_MASK = 24'h000000;
   localparam logic [23:0] R28_RESET = 24'h21284a;
   localparam logic [23:0] R28_MODE_MASK = 24'h003c0f;

   localparam logic [23:0] R29_MAIN_MASK = 24'h000f0f;
   localparam logic [23:0] R29_OFF_MASK = 24'h003030;
   localparam logic [23:0] R29_KEEP_MASK = 24'h100000;
   localparam logic [23:0] R29_RESET = 24'h000a0a;
   localparam logic [23:0] R29_MODE_MASK = 24'h000f0f;

   localparam logic [23:0] R30_MAIN_MASK = 24'h074003;
   localparam logic [23:0] R30_OFF_MASK = 24'h000000;
   localparam logic [23:0] R30_KEEP_MASK = 24'h001ff0;
   localparam logic [23:0] R30_RESET = 24'h024000;
endpackage : blr_pkg
`default_nettype wire

// ---- rtl/blr_reg24.sv ----
`default_nettype none
module blr_reg24 #(
   parameter int W = 24,
   parameter logic [W-1:0] MAIN_MASK = '0,
   parameter logic [W-1:0] OFF_MASK = '0,
   parameter logic [W-1:0] KEEP_MASK = '0,
   parameter logic [W-1:0] RESET_VAL = '0,
   parameter logic [W-1:0] LOAD_MASK = '0
) (
   // clock and the two reset classes
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic off_rst_n_in,
   // host write
   input wire logic wr_en_in,
   input wire logic [W-1:0] wr_data_in,
   // sequencer reload
   input wire logic load_en_in,
   input wire logic [W-1:0] load_data_in,
   // stored value, read-only bits zero
   output logic [W-1:0] q_out
);
   localparam logic [W-1:0] WRITABLE = MAIN_MASK | OFF_MASK | KEEP_MASK;

   logic [W-1:0] main_q;
   logic [W-1:0] off_q;
   logic [W-1:0] keep_q;
   logic [W-1:0] next_val;

   // read-only positions drop the write
   always_comb begin
      next_val = q_out;
      if (wr_en_in) begin
         next_val = (q_out & ~WRITABLE) | (wr_data_in & WRITABLE);
      end
      // sequencer reload wins over a host write in the same cycle
      if (load_en_in) begin
         next_val = (next_val & ~LOAD_MASK) | (load_data_in & LOAD_MASK);
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         main_q <= RESET_VAL & MAIN_MASK;
      end else begin
         main_q <= next_val & MAIN_MASK;
      end
   end

   always_ff @(posedge clk_in or negedge off_rst_n_in) begin
      if (!off_rst_n_in) begin
         off_q <= '0;
      end else begin
         off_q <= next_val & OFF_MASK;
      end
   end

   // no reset at all: contents survive every reset, unknown at power-up
   always_ff @(posedge clk_in) begin
      keep_q <= next_val & KEEP_MASK;
   end

   assign q_out = main_q | off_q | keep_q;
endmodule : blr_reg24
`default_nettype wire

// ---- rtl/blr_buck_ldo_regs.sv ----
// Summary of operation
// - buck four normal level, bits 0-4, unreset
// - buck four standby level, bits 10-14, unreset
// - bit 23 range select, writable, unreset
// - bits 15-22 zero; bits 5-9 spare storage
// - sequencer reloads mode fields from power-up pins
// - enabled buck defaults to pulse-width mode
// - buck one/two modes at 0-3/10-13, reset 1010
// - hold and user-off bits cleared by off reset
// - speed fields 6-7 and 16-17, reset 01
// - bit 8 signal scaling, bit 18 PLL, reset 0
// - bits 19-21 PLL multiplier, reset 100
// - bit 22 current-limit disable; 9, 23 zero
// - buck three/four modes, hold and user-off bits
// - bit 20 boost enable unreset; other unused zero
// - regulator levels one, three, camera, spare reset
// - digital, gen two, PLL, USB levels unreset
`default_nettype none
module blr_buck_ldo_regs
   import blr_pkg::*;
(
   // clock and resets
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic off_state_reset_n_in,
   // register port from the serial interface decoder
   input wire logic [blr_pkg::ADDR_W-1:0] addr_in,
   input wire logic wr_en_in,
   input wire logic [blr_pkg::DATA_W-1:0] wr_data_in,
   input wire logic rd_en_in,
   output logic [blr_pkg::DATA_W-1:0] rd_data_out,
   output logic rd_hit_out,
   // startup sequencer reload from the power-up mode pins
   input wire logic mode_reload_in,
   input wire logic [blr_pkg::MODE_W-1:0] buck_one_mode_default_in,
   input wire logic [blr_pkg::MODE_W-1:0] buck_two_mode_default_in,
   input wire logic [blr_pkg::MODE_W-1:0] buck_three_mode_default_in,
   input wire logic [blr_pkg::MODE_W-1:0] buck_four_mode_default_in,
   // buck four levels
   output logic [4:0] buck_four_normal_level_out,
   output logic [4:0] buck_four_standby_level_out,
   output logic buck_four_range_select_out,
   // buck operating modes
   output logic [blr_pkg::MODE_W-1:0] buck_one_mode_out,
   output logic [blr_pkg::MODE_W-1:0] buck_two_mode_out,
   output logic [blr_pkg::MODE_W-1:0] buck_three_mode_out,
   output logic [blr_pkg::MODE_W-1:0] buck_four_mode_out,
   output logic [3:0] memory_hold_out,
   output logic [3:0] user_off_out,
   // scaling, switcher PLL, current limit, boost
   output logic [1:0] buck_one_scaling_speed_out,
   output logic [1:0] buck_two_scaling_speed_out,
   output logic signal_scaling_enable_out,
   output logic switcher_pll_enable_out,
   output logic [2:0] switcher_pll_multiplier_out,
   output logic current_limit_disable_out,
   output logic boost_enable_out,
   // linear regulator levels
   output logic [1:0] general_regulator_one_out,
   output logic [1:0] digital_regulator_out,
   output logic [2:0] general_regulator_two_out,
   output logic [1:0] pll_regulator_out,
   output logic [1:0] second_usb_regulator_out,
   output logic general_regulator_three_out,
   output logic [1:0] camera_regulator_out
);
   import blr_pkg::*;

   logic [DATA_W-1:0] r27_q;
   logic [DATA_W-1:0] r28_q;
   logic [DATA_W-1:0] r29_q;
   logic [DATA_W-1:0] r30_q;
   logic [DATA_W-1:0] r28_load;
   logic [DATA_W-1:0] r29_load;
   logic [DATA_W-1:0] next_rd_data;
   logic next_rd_hit;

   // mode defaults from the pins placed into their register lanes
   always_comb begin
      r28_load = '0;
      r29_load = '0;
      r28_load[B1_MODE_LSB +: MODE_W] = buck_one_mode_default_in;
      r28_load[B2_MODE_LSB +: MODE_W] = buck_two_mode_default_in;
      r29_load[B3_MODE_LSB +: MODE_W] = buck_three_mode_default_in;
      r29_load[B4_MODE_LSB +: MODE_W] = buck_four_mode_default_in;
   end

   // unreset levels, range and spare storage
   blr_reg24 #(
      .W(DATA_W), .MAIN_MASK(R27_MAIN_MASK), .OFF_MASK(R27_OFF_MASK),
      .KEEP_MASK(R27_KEEP_MASK), .RESET_VAL(R27_RESET), .LOAD_MASK('0)
   ) u_buck_four_levels (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .off_rst_n_in(off_state_reset_n_in),
      .wr_en_in(wr_en_in && addr_in == BUCK_FOUR_LEVELS_ADDR), .wr_data_in(wr_data_in),
      .load_en_in(1'b0), .load_data_in('0), .q_out(r27_q)
   );

   // modes 1010 = pulse-width, no skipping, in normal and standby
   blr_reg24 #(
      .W(DATA_W), .MAIN_MASK(R28_MAIN_MASK), .OFF_MASK(R28_OFF_MASK),
      .KEEP_MASK(R28_KEEP_MASK), .RESET_VAL(R28_RESET), .LOAD_MASK(R28_MODE_MASK)
   ) u_buck_one_two_modes (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .off_rst_n_in(off_state_reset_n_in),
      .wr_en_in(wr_en_in && addr_in == BUCK_ONE_TWO_MODES_ADDR), .wr_data_in(wr_data_in),
      .load_en_in(mode_reload_in), .load_data_in(r28_load), .q_out(r28_q)
   );

   blr_reg24 #(
      .W(DATA_W), .MAIN_MASK(R29_MAIN_MASK), .OFF_MASK(R29_OFF_MASK),
      .KEEP_MASK(R29_KEEP_MASK), .RESET_VAL(R29_RESET), .LOAD_MASK(R29_MODE_MASK)
   ) u_buck_three_four_modes (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .off_rst_n_in(off_state_reset_n_in),
      .wr_en_in(wr_en_in && addr_in == BUCK_THREE_FOUR_MODES_ADDR),
      .wr_data_in(wr_data_in),
      .load_en_in(mode_reload_in), .load_data_in(r29_load), .q_out(r29_q)
   );

   blr_reg24 #(
      .W(DATA_W), .MAIN_MASK(R30_MAIN_MASK), .OFF_MASK(R30_OFF_MASK),
      .KEEP_MASK(R30_KEEP_MASK), .RESET_VAL(R30_RESET), .LOAD_MASK('0)
   ) u_linear_regulator_levels (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .off_rst_n_in(off_state_reset_n_in),
      .wr_en_in(wr_en_in && addr_in == LINEAR_REGULATOR_LEVELS_ADDR),
      .wr_data_in(wr_data_in),
      .load_en_in(1'b0), .load_data_in('0), .q_out(r30_q)
   );

   // other addresses belong to neighbouring banks: answer zero, no hit
   always_comb begin
      next_rd_data = rd_data_out;
      next_rd_hit = rd_hit_out;
      if (rd_en_in) begin
         next_rd_hit = 1'b1;
         case (addr_in)
            BUCK_FOUR_LEVELS_ADDR: next_rd_data = r27_q;
            BUCK_ONE_TWO_MODES_ADDR: next_rd_data = r28_q;
            BUCK_THREE_FOUR_MODES_ADDR: next_rd_data = r29_q;
            LINEAR_REGULATOR_LEVELS_ADDR: next_rd_data = r30_q;
            default: begin
               next_rd_data = '0;
               next_rd_hit = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rd_data_out <= '0;
         rd_hit_out <= 1'b0;
      end else begin
         rd_data_out <= next_rd_data;
         rd_hit_out <= next_rd_hit;
      end
   end

   // field outputs are the register flops themselves
   assign buck_four_normal_level_out = r27_q[B4_NORMAL_LSB +: 5];
   assign buck_four_standby_level_out = r27_q[B4_STANDBY_LSB +: 5];
   assign buck_four_range_select_out = r27_q[B4_RANGE_BIT];
   assign buck_one_mode_out = r28_q[B1_MODE_LSB +: MODE_W];
   assign buck_two_mode_out = r28_q[B2_MODE_LSB +: MODE_W];
   assign buck_three_mode_out = r29_q[B3_MODE_LSB +: MODE_W];
   assign buck_four_mode_out = r29_q[B4_MODE_LSB +: MODE_W];
   assign memory_hold_out = {r29_q[B4_HOLD_BIT], r29_q[B3_HOLD_BIT],
                             r28_q[B2_HOLD_BIT], r28_q[B1_HOLD_BIT]};
   assign user_off_out = {r29_q[B4_USER_OFF_BIT], r29_q[B3_USER_OFF_BIT],
                          r28_q[B2_USER_OFF_BIT], r28_q[B1_USER_OFF_BIT]};
   assign buck_one_scaling_speed_out = r28_q[B1_SPEED_LSB +: 2];
   assign buck_two_scaling_speed_out = r28_q[B2_SPEED_LSB +: 2];
   assign signal_scaling_enable_out = r28_q[SIGNAL_SCALING_BIT];
   assign switcher_pll_enable_out = r28_q[PLL_ENABLE_BIT];
   assign switcher_pll_multiplier_out = r28_q[PLL_MULT_LSB +: 3];
   assign current_limit_disable_out = r28_q[ILIM_DISABLE_BIT];
   assign boost_enable_out = r29_q[BOOST_ENABLE_BIT];
   assign general_regulator_one_out = r30_q[GEN1_LSB +: 2];
   assign digital_regulator_out = r30_q[DIGITAL_LSB +: 2];
   assign general_regulator_two_out = r30_q[GEN2_LSB +: 3];
   assign pll_regulator_out = r30_q[PLL_REG_LSB +: 2];
   assign second_usb_regulator_out = r30_q[USB2_LSB +: 2];
   assign general_regulator_three_out = r30_q[GEN3_BIT];
   assign camera_regulator_out = r30_q[CAMERA_LSB +: 2];
endmodule : blr_buck_ldo_regs
`default_nettype wire

// ---- test/blr_host.sv ----
`default_nettype none
module blr_host (
   // clock
   input wire logic clk_in,
   // register port towards the device
   output logic [5:0] addr_out,
   output logic wr_en_out,
   output logic [23:0] wr_data_out,
   output logic rd_en_out,
   input wire logic [23:0] rd_data_in,
   input wire logic rd_hit_in
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      addr_out = 6'h00;
      wr_en_out = 1'b0;
      wr_data_out = 24'h000000;
      rd_en_out = 1'b0;
   end
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      @(negedge clk_in);
      addr_out = a;
      wr_data_out = d;
      wr_en_out = 1'b1;
      @(negedge clk_in);
      wr_en_out = 1'b0;
      // released data must not keep showing the last word
      wr_data_out = ~d;
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic h);
      @(negedge clk_in);
      addr_out = a;
      rd_en_out = 1'b1;
      @(negedge clk_in);
      rd_en_out = 1'b0;
      @(negedge clk_in);
      d = rd_data_in;
      h = rd_hit_in;
   endtask : rd
endmodule : blr_host
`default_nettype wire

// ---- test/blr_regs_sva.sv ----
`default_nettype none
module blr_regs_sva
   import blr_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic off_state_reset_n_in,
   input wire logic [blr_pkg::ADDR_W-1:0] addr_in,
   input wire logic wr_en_in,
   input wire logic [blr_pkg::DATA_W-1:0] wr_data_in,
   input wire logic rd_en_in,
   input wire logic [blr_pkg::DATA_W-1:0] rd_data_out,
   input wire logic rd_hit_out,
   input wire logic mode_reload_in,
   input wire logic [blr_pkg::MODE_W-1:0] buck_one_mode_default_in,
   input wire logic [blr_pkg::MODE_W-1:0] buck_four_mode_default_in,
   input wire logic [4:0] buck_four_normal_level_out,
   input wire logic [4:0] buck_four_standby_level_out,
   input wire logic buck_four_range_select_out,
   input wire logic [blr_pkg::MODE_W-1:0] buck_one_mode_out,
   input wire logic [blr_pkg::MODE_W-1:0] buck_four_mode_out,
   input wire logic [3:0] memory_hold_out,
   input wire logic [3:0] user_off_out,
   input wire logic [1:0] buck_one_scaling_speed_out,
   input wire logic switcher_pll_enable_out,
   input wire logic [2:0] switcher_pll_multiplier_out,
   input wire logic boost_enable_out,
   input wire logic general_regulator_three_out,
   input wire logic [1:0] camera_regulator_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   AST_MODE_RST: assert property ($rose(rst_n_in) |->
      buck_one_mode_out == 4'ha && buck_four_mode_out == 4'ha)
      else $error("mode field not 1010 after reset");
   AST_CFG_RST: assert property ($rose(rst_n_in) |->
      switcher_pll_multiplier_out == 3'h4 && buck_one_scaling_speed_out == 2'h1
      && !switcher_pll_enable_out && general_regulator_three_out
      && camera_regulator_out == 2'h2)
      else $error("reset field value wrong");
   AST_B4_WR: assert property (wr_en_in && addr_in == 6'h1b |=>
      (({buck_four_range_select_out, 8'h00, buck_four_standby_level_out, 5'h00,
      buck_four_normal_level_out} ^ $past(wr_data_in)) & 24'h807c1f) == 24'h0)
      else $error("buck four level fields miss the write");
   AST_BOOST_WR: assert property (wr_en_in && addr_in == 6'h1d |=>
      (24'(boost_enable_out) << 20) == ($past(wr_data_in) & 24'h100000))
      else $error("boost enable misses the write");
   AST_RELOAD: assert property (mode_reload_in |=>
      buck_one_mode_out == $past(buck_one_mode_default_in)
      && buck_four_mode_out == $past(buck_four_mode_default_in))
      else $error("mode reload not taken");
   AST_OFF: assert property (!off_state_reset_n_in |->
      memory_hold_out == 4'h0 && user_off_out == 4'h0)
      else $error("hold or user-off set in off reset");
   AST_R29_ZERO: assert property (rd_en_in && addr_in == 6'h1d |=>
      (rd_data_out & 24'hefc0c0) == 24'h0)
      else $error("unused bits read nonzero");
   AST_UNMAPPED: assert property (
      rd_en_in && (addr_in < 6'h1b || addr_in > 6'h1e) |=> rd_data_out == 24'h0 && !rd_hit_out)
      else $error("unmapped read not empty");
endmodule : blr_regs_sva
bind blr_buck_ldo_regs blr_regs_sva u_sva (.clk_in, .rst_n_in, .off_state_reset_n_in,
   .addr_in, .wr_en_in, .wr_data_in, .rd_en_in, .rd_data_out, .rd_hit_out,
   .mode_reload_in, .buck_one_mode_default_in, .buck_four_mode_default_in,
   .buck_four_normal_level_out, .buck_four_standby_level_out, .buck_four_range_select_out,
   .buck_one_mode_out, .buck_four_mode_out, .memory_hold_out, .user_off_out,
   .buck_one_scaling_speed_out, .switcher_pll_enable_out, .switcher_pll_multiplier_out,
   .boost_enable_out, .general_regulator_three_out, .camera_regulator_out);
`default_nettype wire

// ---- test/tb.sv ----
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import blr_pkg::*;
   logic clk_in, rst_n_in, off_n, wr_en, rd_en, reload, hit, rng;
   logic [5:0] addr, a;
   logic [23:0] wd, rdat, got, d;
   logic [31:0] seed;
   logic [3:0] def [4];
   logic [3:0] m1, m2, m3, m4, hold, uoff;
   logic [4:0] nrm, sby;
   logic hs, signal_driven_scaling, pll, ilim, bst, g3;
   logic [1:0] sp1, sp2, g1, dg, pr, u2, cam;
   logic [2:0] mul, g2;
   int fail_count = 0;
   int comparisons = 0;
   blr_host host (.clk_in(clk_in), .addr_out(addr), .wr_en_out(wr_en), .wr_data_out(wd),
      .rd_en_out(rd_en), .rd_data_in(rdat), .rd_hit_in(hit));
   blr_buck_ldo_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in),
      .off_state_reset_n_in(off_n), .addr_in(addr), .wr_en_in(wr_en), .wr_data_in(wd),
      .rd_en_in(rd_en), .rd_data_out(rdat), .rd_hit_out(hit), .mode_reload_in(reload),
      .buck_one_mode_default_in(def[0]), .buck_two_mode_default_in(def[1]),
      .buck_three_mode_default_in(def[2]), .buck_four_mode_default_in(def[3]),
      .buck_four_normal_level_out(nrm), .buck_four_standby_level_out(sby),
      .buck_four_range_select_out(rng), .buck_one_mode_out(m1), .buck_two_mode_out(m2),
      .buck_three_mode_out(m3), .buck_four_mode_out(m4), .memory_hold_out(hold),
      .user_off_out(uoff), .buck_one_scaling_speed_out(sp1),
      .buck_two_scaling_speed_out(sp2), .signal_scaling_enable_out(signal_driven_scaling),
      .switcher_pll_enable_out(pll), .switcher_pll_multiplier_out(mul),
      .current_limit_disable_out(ilim), .boost_enable_out(bst),
      .general_regulator_one_out(g1), .digital_regulator_out(dg),
      .general_regulator_two_out(g2), .pll_regulator_out(pr),
      .second_usb_regulator_out(u2), .general_regulator_three_out(g3),
      .camera_regulator_out(cam));
   task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic conclude();
      if (fail_count == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : conclude
   function automatic logic [23:0] wmask(input logic [5:0] x);
      case (x)
         6'h1b: return 24'h807fff;
         6'h1c: return 24'h7ffdff;
         6'h1d: return 24'h103f3f;
         6'h1e: return 24'h075ff3;
         default: return 24'h000000;
      endcase
   endfunction : wmask
   task automatic rdchk(input logic [5:0] x, input logic [23:0] m, input logic [23:0] e);
      host.rd(x, got, hs);
      chk(got & m, e);
   endtask : rdchk
   initial begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial begin
      #1ms;
      fail_count++;
      conclude();
   end
   initial begin
      rst_n_in = 1'b0;
      off_n = 1'b0;
      reload = 1'b0;
      foreach (def[k]) def[k] = 4'h0;
      seed = $urandom(32'h6c78);
      repeat (8) @(negedge clk_in);
      rst_n_in = 1'b1;
      off_n = 1'b1;
      // unreset bits are unknown here, so they are masked off
      rdchk(6'h1b, 24'h7f8000, 24'h0);
      rdchk(6'h1c, 24'hffffff, 24'h21284a);
      rdchk(6'h1d, 24'hefffff, 24'h000a0a);
      rdchk(6'h1e, 24'hffe00f, 24'h024000);
      for (int i = 0; i < 60; i++) begin
         a = (i % 6 == 4) ? 6'h1a : (i % 6 == 5) ? 6'h1f : 6'(6'h1b + i % 4);
         d = (i < 4) ? 24'hffffff : 24'($urandom);
         host.wr(a, d);
         host.rd(a, got, hs);
         chk(got, d & wmask(a));
         chk(24'(hs), 24'(wmask(a) != 24'h0));
         if (a == 6'h1b) chk(24'({rng, sby, nrm}), 24'({d[23], d[14:10], d[4:0]}));
         if (a == 6'h1c) chk(24'({ilim, mul, pll, sp2, signal_driven_scaling, sp1}), 24'({d[22:16], d[8:6]}));
         if (a == 6'h1d) chk(24'(bst), 24'(d[20]));
         if (a == 6'h1e) chk(24'({cam, g3, u2, pr, g2, dg, g1}), 24'({d[17:16], d[14], d[12:4], d[1:0]}));
      end
      for (int i = 0; i < 4; i++) host.wr(6'(6'h1b + i), 24'hffffff);
      @(negedge clk_in) rst_n_in = 1'b0;
      @(negedge clk_in) rst_n_in = 1'b1;
      rdchk(6'h1b, 24'hffffff, 24'h807fff);
      rdchk(6'h1c, 24'hffffff, 24'h21e87a);
      rdchk(6'h1d, 24'hffffff, 24'h103a3a);
      rdchk(6'h1e, 24'hffffff, 24'h025ff0);
      chk(24'({hold, uoff}), 24'hff);
      @(negedge clk_in) off_n = 1'b0;
      @(negedge clk_in) off_n = 1'b1;
      chk(24'({hold, uoff}), 24'h0);
      rdchk(6'h1c, 24'hffffff, 24'h21284a);
      rdchk(6'h1d, 24'hffffff, 24'h100a0a);
      repeat (3) begin
         foreach (def[k]) def[k] = 4'($urandom);
         @(negedge clk_in) reload = 1'b1;
         @(negedge clk_in) reload = 1'b0;
         chk(24'({m1, m2, m3, m4}), 24'({def[0], def[1], def[2], def[3]}));
      end
      conclude();
   end
endmodule : tb
`default_nettype wire
